// File: rtl/isc_pkg.sv
// Package for the interrupt status collector: register map, bit positions and timing.
// Assumes a 32-bit APB register bus and a single 50 MHz system clock.
package isc_pkg;
	localparam logic [11:0] ADDR_INT_STATUS = 12'h00C;   // Interrupt status register byte offset.
	localparam logic [11:0] ADDR_SRC_CTRL   = 12'h010;   // Energy saving enable and MAC reset request.
	localparam logic [11:0] ADDR_SRC_STATUS = 12'h014;   // Live source and MAC reset state.
	localparam int          BIT_RX_IDLE     = 24;        // Receive idle entry flag.
	localparam int          BIT_MAC_RTO     = 23;        // MAC reset timeout flag.
	localparam int          BIT_RX_OVF      = 22;        // Receive FIFO overflow flag.
	localparam int          BIT_TX_ERR      = 21;        // Transmit error flag.
	localparam int          BIT_USB_EVT     = 20;        // USB event flag.
	localparam int          BIT_TX_STOP     = 19;        // Transmit stopped flag.
	localparam int          BIT_RX_STOP     = 18;        // Receive stopped flag.
	localparam int          BIT_PHY_EVT     = 17;        // PHY event flag.
	localparam int          BIT_DP_DONE     = 16;        // Data port done flag.
	localparam int          BIT_MAC_FAULT   = 15;        // MAC fault flag.
	localparam int          BIT_UTX_WAIT    = 12;        // USB transmit frame waiting.
	localparam int          CTRL_ENERGY     = 0;         // Control bit: energy saving enable.
	localparam int          CTRL_MAC_RST    = 1;         // Control bit: MAC reset request.
	localparam int          GPIO_COUNT      = 12;        // Number of pin event flags.
	localparam logic [31:0] STATUS_MASK     = 32'h01FF9FFF; // Implemented status bits.
	localparam logic [31:0] RESET_ZERO      = 32'h00000000; // Reset value of latched bits.
	localparam int          CLK_HZ          = 50000000;  // System clock rate.
	localparam int          WDOG_MS         = 8;         // MAC reset watchdog time in ms.
	localparam int          WDOG_CYCLES     = (CLK_HZ / 1000) * WDOG_MS; // Longest time, rounded down.
	typedef enum logic [2:0]
	{
		ISC_RST_IDLE = 3'b001,
		ISC_RST_WAIT = 3'b010,
		ISC_RST_DONE = 3'b100
	} isc_rst_e;
endpackage

// File: rtl/interrupt_status_collector.sv
// Interrupt status collector: bits 24 to 0 of the device interrupt status register, behind APB.
// Assumes pulse sources are one clock wide and synchronous; pins and the PHY line are asynchronous.
//
// What this block does
// RULE_01 - Set bit 24 on receive idle entry.
// RULE_02 - Hold bit 24 low while energy saving off.
// RULE_03 - Pulse bits latch until software clears them.
// RULE_04 - Level bits stay set while source active.
// RULE_05 - 8 ms MAC reset watchdog sets bit 23.
// RULE_06 - Watchdog expiry releases MAC reset without clocks.
// RULE_07 - Bit 22 set on write to full FIFO.
// RULE_08 - Discard receive data while overflow flag set.
// RULE_09 - Bit 21 follows transmitter error level.
// RULE_10 - Bit 20 held until USB events cleared.
// RULE_11 - Bit 19 held while transmit disabled.
// RULE_12 - Bit 18 held while receive disabled.
// RULE_13 - Bit 17 reflects PHY interrupt line.
// RULE_14 - Bit 16 set on data port completion.
// RULE_15 - Bit 15 held while MAC faults remain.
// RULE_16 - Bit 12 shows USB frame waiting.
// RULE_17 - Twelve pin flags, reset follows pin state.
// RULE_18 - Clearing pin flag clears its wake event.
// RULE_19 - Status register is 32 bits at 0x00C.
// RULE_20 - Reserved bits 14, 13 read zero.
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_collector
	import isc_pkg::*;
#(
	parameter int WDOG_LIMIT = WDOG_CYCLES                // Watchdog length in cycles.
)
(
	input  wire logic                  clk_sys,          // System clock, 50 MHz.
	input  wire logic                  rst_n,            // Synchronous reset, active low.
	input  wire logic                  clkEn,            // Clock enable; low freezes all state.
	input  wire logic                  psel,             // APB select.
	input  wire logic                  penable,          // APB enable.
	input  wire logic                  pwrite,           // APB write.
	input  wire logic [11:0]           paddr,            // APB byte address.
	input  wire logic [31:0]           pwdata,           // APB write data.
	output logic                       pready,           // APB ready.
	output logic [31:0]                prdata,           // APB read data.
	output logic                       pslverr,          // APB error for unmapped address.
	input  wire logic                  rxIdleEntry,      // Pulse: receiver entered low power idle.
	input  wire logic                  phyClocksOk,      // Level: PHY clocks seen by MAC.
	output logic                       macResetActive,   // MAC reset held.
	input  wire logic                  rxFifoFull,       // Level: receive FIFO full.
	input  wire logic                  rxWriteReq,       // Receive logic write attempt.
	output logic                       rxWriteEn,        // Write allowed into FIFO.
	input  wire logic                  txError,          // Level: transmitter error.
	input  wire logic                  usbEventAny,      // Level: USB status event pending.
	input  wire logic                  txFifoStopped,    // Level: transmit FIFO disabled.
	input  wire logic                  macTxStopped,     // Level: MAC transmitter disabled.
	input  wire logic                  rxFifoStopped,    // Level: receive FIFO disabled.
	input  wire logic                  macRxStopped,     // Level: MAC receiver disabled.
	input  wire logic                  phyIrqPin,        // Asynchronous PHY interrupt line.
	input  wire logic                  dataPortDone,     // Pulse: data port operation done.
	input  wire logic                  macFaultAny,      // Level: any MAC fault bit set.
	input  wire logic                  usbTxFrameWaiting,// Level: USB TX FIFO has a frame.
	input  wire logic [GPIO_COUNT-1:0] gpioPins,         // Asynchronous GPIO event levels.
	output logic [GPIO_COUNT-1:0]      wakeClear,        // Pulse: clear matching wake event.
	output logic                       energySavingEn    // Energy saving enable control.
);
	// Two-flop synchronisers for the pin-sourced levels; first stage feeds only the second.
	logic [GPIO_COUNT:0] syncMeta;                       // First stage.
	logic [GPIO_COUNT:0] syncLive;                       // Second stage, safe to read.
	logic [31:0]         latched;                        // Sticky status bits.
	logic [31:0]         levels;                         // Live level sources in position.
	logic [31:0]         statusView;                     // Value software sees.
	logic [31:0]         clearMask;                      // Write-one-to-clear mask this cycle.
	logic                macResetReq;                    // Software MAC reset request.
	logic                rstPending;                     // High for the whole ISC_RST_WAIT state; holds the MAC reset.
	logic                wdogExpire;                     // Watchdog expired this cycle.
	logic                gpioSeeded;                     // Pin flags loaded after reset.
	logic [31:0]         wdogCount;                      // Watchdog counter.
	isc_rst_e            rstState;                       // MAC reset state.
	isc_rst_e            next_rstState;                  // Next MAC reset state.
	logic                apbWrite;                       // Write access phase.
	logic                apbRead;                        // Read access phase.

	// Decode a byte address against the implemented registers.
	function automatic logic isMapped(input logic [11:0] a);
		isMapped = (a == ADDR_INT_STATUS) || (a == ADDR_SRC_CTRL) || (a == ADDR_SRC_STATUS);
	endfunction

	assign apbWrite = psel && penable && pwrite;
	assign apbRead  = psel && penable && !pwrite;
	// Zero-wait slave: ready in every access phase.
	// Limitation: ready ignores clkEn, so a transfer made while the enable is low ends on the bus
	// but changes no register; a master holds off while the enable is low.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !isMapped(paddr);

	// Synchronise PHY line and GPIO pins before any logic looks at them.
	// Trade-off: two cycles of latency on these flags buy freedom from metastability.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			syncMeta <= '0;
			syncLive <= '0;
		end
		else if (clkEn)
		begin
			syncMeta <= {phyIrqPin, gpioPins};
			syncLive <= syncMeta;
		end
	end

	// Software clear mask: writes to the status word only, reserved bits ignored.
	assign clearMask = (apbWrite && paddr == ADDR_INT_STATUS) ? (pwdata & STATUS_MASK) : RESET_ZERO; // [RULE_20]

	// Level sources mapped into their bit positions.
	// Bit 22 enters here too: it is latched like any level and then held by the sticky path.
	always_comb
	begin
		levels                = RESET_ZERO;
		levels[BIT_TX_ERR]    = txError;                          // [RULE_09]
		levels[BIT_USB_EVT]   = usbEventAny;                      // [RULE_10]
		levels[BIT_TX_STOP]   = txFifoStopped || macTxStopped;    // [RULE_11]
		levels[BIT_RX_STOP]   = rxFifoStopped || macRxStopped;    // [RULE_12]
		levels[BIT_PHY_EVT]   = syncLive[GPIO_COUNT];             // [RULE_13]
		levels[BIT_MAC_FAULT] = macFaultAny;                      // [RULE_15]
		levels[BIT_RX_OVF]    = rxWriteReq && rxFifoFull;         // [RULE_07]
		levels[GPIO_COUNT-1:0] = syncLive[GPIO_COUNT-1:0];        // [RULE_17]
	end

	// Sticky bits: a set in the same cycle as a clear wins, and live levels re-assert at once.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			latched <= RESET_ZERO;
		end
		else if (clkEn)
		begin
			latched <= (latched & ~clearMask) | levels;           // [RULE_04]
			latched[BIT_RX_IDLE] <= energySavingEn &&
				((latched[BIT_RX_IDLE] && !clearMask[BIT_RX_IDLE]) || rxIdleEntry); // [RULE_01] [RULE_02] [RULE_03]
			latched[BIT_MAC_RTO] <= (latched[BIT_MAC_RTO] && !clearMask[BIT_MAC_RTO]) || wdogExpire; // [RULE_05]
			latched[BIT_DP_DONE] <= (latched[BIT_DP_DONE] && !clearMask[BIT_DP_DONE]) || dataPortDone; // [RULE_14]
			latched[BIT_UTX_WAIT] <= usbTxFrameWaiting;          // [RULE_16]
			if (!gpioSeeded)
			begin
				// Pin flags are loaded from the synchroniser on the first two edges, before it has filled.
				latched[GPIO_COUNT-1:0] <= syncLive[GPIO_COUNT-1:0]; // [RULE_17]
			end
		end
	end

	// The pin seed is last taken two edges after reset release, before the synchroniser holds real pin levels.
	// Pin flags read as zero until the third enabled edge after reset, so software waits.
	logic [1:0] seedCount;                                  // Counts synchroniser fill.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			seedCount  <= 2'h0;
			gpioSeeded <= 1'b0;
		end
		else if (clkEn && !gpioSeeded)
		begin
			seedCount  <= seedCount + 2'h1;
			gpioSeeded <= (seedCount == 2'h1);
		end
	end

	// Software clear of a pin flag also clears the matching wake event.
	// The pulse goes out even when the flag was clear; an extra wake clear is harmless.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wakeClear <= '0;
		end
		else if (clkEn)
		begin
			wakeClear <= clearMask[GPIO_COUNT-1:0];              // [RULE_18]
		end
	end

	// Receive data is dropped while overflow is flagged, and whenever the FIFO is full.
	// Dropping on full as well costs nothing: the FIFO could not take the word anyway.
	assign rxWriteEn = rxWriteReq && !rxFifoFull && !latched[BIT_RX_OVF]; // [RULE_08]

	// Control register: energy saving enable and a MAC reset request pulse.
	// The reset request reads back as one only in the cycle after the write.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			energySavingEn <= 1'b0;
			macResetReq    <= 1'b0;
		end
		else if (clkEn)
		begin
			macResetReq <= 1'b0;
			if (apbWrite && paddr == ADDR_SRC_CTRL)
			begin
				energySavingEn <= pwdata[CTRL_ENERGY];
				macResetReq    <= pwdata[CTRL_MAC_RST];
			end
		end
	end

	// MAC reset sequencer: waits for PHY clocks or the watchdog, whichever comes first.
	// The watchdog length is rounded down to whole cycles of the system clock.
	always_comb
	begin
		next_rstState = rstState;
		case (rstState)
			ISC_RST_IDLE: if (macResetReq) next_rstState = ISC_RST_WAIT;
			ISC_RST_WAIT:
				if (phyClocksOk || wdogExpire) next_rstState = ISC_RST_DONE;  // [RULE_06]
			ISC_RST_DONE: next_rstState = ISC_RST_IDLE;
			default:      next_rstState = ISC_RST_IDLE;
		endcase
	end
	assign rstPending     = (rstState == ISC_RST_WAIT);
	assign wdogExpire     = rstPending && (wdogCount == WDOG_LIMIT - 1);  // [RULE_05]
	// Release is a plain gate on state, so it needs no PHY-supplied clock edge.
	assign macResetActive = rstPending;                                   // [RULE_06]

	// State register and watchdog counter.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rstState  <= ISC_RST_IDLE;
			wdogCount <= 32'h00000000;
		end
		else if (clkEn)
		begin
			rstState  <= next_rstState;
			wdogCount <= rstPending ? wdogCount + 32'h00000001 : 32'h00000000;
		end
	end

	// Read view: status word with reserved bits forced low.
	assign statusView = latched & STATUS_MASK;               // [RULE_19] [RULE_20]

	// Read data register, loaded in the setup phase so that it stands through the access phase.
	// A read whose setup edge falls while the enable is low returns the previous data.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			prdata <= 32'h00000000;
		end
		else if (clkEn && psel && !penable && !pwrite)
		begin
			case (paddr)
				ADDR_INT_STATUS: prdata <= statusView;
				ADDR_SRC_CTRL:   prdata <= {30'h0, macResetReq, energySavingEn};
				ADDR_SRC_STATUS: prdata <= {29'h0, rxFifoFull, phyClocksOk, macResetActive};
				default:         prdata <= 32'h00000000;
			endcase
		end
	end

	// Checks: relations between sources, state and the flags.
	property pRxIdleGated;
		@(posedge clk_sys) disable iff (!rst_n)
		!energySavingEn |-> ##1 (!latched[BIT_RX_IDLE] || !$past(clkEn));
	endproperty
	a_rx_idle_gate: assert property (pRxIdleGated) else $error("Idle flag set while energy saving off"); // [RULE_02]

	a_rx_idle_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_01]
		clkEn && energySavingEn && rxIdleEntry |=> latched[BIT_RX_IDLE])
		else $error("Idle entry not flagged");

	a_dp_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_03]
		latched[BIT_DP_DONE] && !(clkEn && clearMask[BIT_DP_DONE]) |=> latched[BIT_DP_DONE])
		else $error("Data port flag lost without clear");

	a_level_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_04]
		clkEn && txError |=> latched[BIT_TX_ERR])
		else $error("Level source not reflected");

	sequence sWaitStart;
		rstState == ISC_RST_IDLE ##1 rstState == ISC_RST_WAIT;
	endsequence
	a_wdog_bound: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_05]
		wdogExpire && clkEn |=> latched[BIT_MAC_RTO] && rstState == ISC_RST_DONE)
		else $error("Watchdog expiry not flagged");

	a_rst_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_06]
		sWaitStart ##0 (clkEn && phyClocksOk) |=> !macResetActive)
		else $error("MAC reset not released");

	a_ovf_drop: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
		latched[BIT_RX_OVF] |-> !rxWriteEn)
		else $error("Write passed during overflow");

	a_ovf_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_07]
		clkEn && rxWriteReq && rxFifoFull |=> latched[BIT_RX_OVF])
		else $error("Overflow not flagged");

	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_20]
		apbRead && paddr == ADDR_INT_STATUS |-> prdata[14:13] == 2'h0)
		else $error("Reserved bits not zero");

	a_wake_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_18]
		clkEn && clearMask[0] |=> wakeClear[0])
		else $error("Wake event not cleared");

	// Further checks, one per source path, so that each flag is watched where it is made.
	// Each except a_wdog_range looks one edge ahead, since every flag is a flip-flop.
	// Freeze: with the enable low nothing moves, not even the read data.
	a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!clkEn |=> $stable(latched) && $stable(rstState) && $stable(wdogCount) && $stable(prdata))
		else $error("State moved while clock enable low");

	// A pin level reaches its flag one edge after the synchroniser shows it.
	a_pin_level: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_17]
		clkEn && syncLive[0] |=> latched[0])
		else $error("Pin flag not set by pin level");

	// The PHY line sets its flag only through the synchroniser.
	a_phy_level: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
		clkEn && syncLive[GPIO_COUNT] |=> latched[BIT_PHY_EVT])
		else $error("PHY flag not set");

	// A pending USB event keeps its flag up.
	a_usb_level: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_10]
		clkEn && usbEventAny |=> latched[BIT_USB_EVT])
		else $error("USB event flag not set");

	// Either transmit stop source holds the transmit stopped flag.
	a_tx_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_11]
		clkEn && (txFifoStopped || macTxStopped) |=> latched[BIT_TX_STOP])
		else $error("Transmit stop flag not set");

	// Either receive stop source holds the receive stopped flag.
	a_rx_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_12]
		clkEn && (rxFifoStopped || macRxStopped) |=> latched[BIT_RX_STOP])
		else $error("Receive stop flag not set");

	// Any MAC fault keeps the fault flag up.
	a_fault_level: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_15]
		clkEn && macFaultAny |=> latched[BIT_MAC_FAULT])
		else $error("MAC fault flag not set");

	// The frame waiting bit is a plain copy of its source, one edge late.
	a_utx_follow: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_16]
		clkEn |=> latched[BIT_UTX_WAIT] == $past(usbTxFrameWaiting))
		else $error("Frame waiting bit does not follow source");

	// A data port completion pulse is caught.
	a_dp_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_14]
		clkEn && dataPortDone |=> latched[BIT_DP_DONE])
		else $error("Data port flag not set");

	// Watchdog expiry drops the MAC reset on the very next edge.
	a_rto_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_06]
		clkEn && wdogExpire |=> !macResetActive)
		else $error("MAC reset held after watchdog expiry");

	// The watchdog counter never passes its limit.
	a_wdog_range: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_05]
		rstPending |-> wdogCount < WDOG_LIMIT)
		else $error("Watchdog counter beyond its limit");

	// Wake clears only ever follow a register write.
	a_wake_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_18]
		clkEn && !apbWrite |=> wakeClear == {GPIO_COUNT{1'b0}})
		else $error("Wake clear without a write");

	// A status read returns the view as it stood at its setup edge.
	a_status_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_19]
		clkEn && psel && !penable && !pwrite && paddr == ADDR_INT_STATUS |=> prdata == $past(statusView))
		else $error("Status read data wrong");

	// A timeout flag clear, with no expiry competing, takes effect at once.
	sequence sRtoClear;
		clkEn && clearMask[BIT_MAC_RTO] && !wdogExpire;
	endsequence
	a_rto_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_03]
		sRtoClear |=> !latched[BIT_MAC_RTO])
		else $error("Timeout flag not cleared");
endmodule
`default_nettype wire

// File: sim/interrupt_status_collector_test.sv
// Self-checking bench for the interrupt status collector, driven over APB.
// Assumes isc_pkg is compiled first; the slave answers every access with pready high.
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_collector_test;
	import isc_pkg::*;
	localparam int WDOG_SIM = 20;           // Short watchdog so the timeout case runs quickly.
	logic        clk_sys = 1'b0;            // System clock.
	logic        rst_n = 1'b0;              // Synchronous reset, active low.
	logic        clkEn = 1'b1;              // Clock enable.
	logic        psel = 1'b0;               // APB select.
	logic        penable = 1'b0;            // APB enable.
	logic        pwrite = 1'b0;             // APB direction.
	logic [11:0] paddr = 12'h000;           // APB address.
	logic [31:0] pwdata = 32'h00000000;     // APB write data.
	logic        pready;                    // APB ready.
	logic [31:0] prdata;                    // APB read data.
	logic        pslverr;                   // APB error.
	logic        rxIdleEntry = 1'b0;        // Idle entry pulse.
	logic        phyClocksOk = 1'b0;        // PHY clocks present.
	logic        macResetActive;            // MAC reset held.
	logic        rxFifoFull = 1'b0;         // Receive FIFO full.
	logic        rxWriteReq = 1'b0;         // Receive write attempt.
	logic        rxWriteEn;                 // Receive write allowed.
	logic        dataPortDone = 1'b0;       // Data port done pulse.
	logic        usbTxFrameWaiting = 1'b0;  // USB frame waiting.
	logic [7:0]  lvlSrc = 8'h00;            // Level sources, one per table entry.
	logic [11:0] gpioPins = 12'hA5A;        // Pin levels, seeded before reset.
	logic [11:0] wakeClear;                 // Wake clear pulses.
	logic [11:0] wakeSeen = 12'h000;        // Every wake clear pulse seen so far.
	logic        energySavingEn;            // Energy saving control.
	int          failures = 0;              // Mismatch count.
	int          checked = 0;               // Comparison count.
	int          lvlPos [8] = '{BIT_TX_ERR, BIT_USB_EVT, BIT_TX_STOP, BIT_TX_STOP,
		BIT_RX_STOP, BIT_RX_STOP, BIT_PHY_EVT, BIT_MAC_FAULT}; // Status bit of each level source.

	interrupt_status_collector #(.WDOG_LIMIT(WDOG_SIM)) u_interrupt_status_collector (
		.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .rxIdleEntry(rxIdleEntry), .phyClocksOk(phyClocksOk),
		.macResetActive(macResetActive), .rxFifoFull(rxFifoFull), .rxWriteReq(rxWriteReq),
		.rxWriteEn(rxWriteEn), .txError(lvlSrc[0]), .usbEventAny(lvlSrc[1]),
		.txFifoStopped(lvlSrc[2]), .macTxStopped(lvlSrc[3]), .rxFifoStopped(lvlSrc[4]),
		.macRxStopped(lvlSrc[5]), .phyIrqPin(lvlSrc[6]), .dataPortDone(dataPortDone),
		.macFaultAny(lvlSrc[7]), .usbTxFrameWaiting(usbTxFrameWaiting), .gpioPins(gpioPins),
		.wakeClear(wakeClear), .energySavingEn(energySavingEn));

	// Free-running 50 MHz clock.
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end

	// Wake clears are pulses, so they are gathered here rather than sampled at one moment.
	always @(posedge clk_sys)
	begin
		wakeSeen <= wakeSeen | wakeClear;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer: setup, access held until pready, answer taken at that edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h00000000, 32'h00000001);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Register read with an expected value.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(r, exp);
	endtask

	// Register write.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	// Cuts a hang short; the whole sequence needs well under this.
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		$display("[ERR] %0t run did not finish", $time);
		test_done();
	end

	// Main sequence of register accesses and source stimulus.
	initial
	begin : main
		logic [31:0] r;
		logic        e;
		int          i;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(ADDR_INT_STATUS, 32'h00000A5A);
		gpioPins <= 12'h000;
		repeat (4) @(posedge clk_sys);
		wr(ADDR_INT_STATUS, 32'h00000A5A);
		repeat (3) @(posedge clk_sys);
		chk({20'h00000, wakeSeen}, 32'h00000A5A);
		rd(ADDR_INT_STATUS, 32'h00000000);
		wr(ADDR_INT_STATUS, 32'h00006000);
		rd(ADDR_INT_STATUS, 32'h00000000);
		// Each level source: set while high, immune to clear until it drops.
		for (i = 0; i < 8; i++)
		begin
			lvlSrc[i] <= 1'b1;
			repeat (4) @(posedge clk_sys);
			rd(ADDR_INT_STATUS, 32'h00000001 << lvlPos[i]);
			wr(ADDR_INT_STATUS, 32'hFFFFFFFF);
			rd(ADDR_INT_STATUS, 32'h00000001 << lvlPos[i]);
			lvlSrc[i] <= 1'b0;
			repeat (4) @(posedge clk_sys);
			wr(ADDR_INT_STATUS, 32'hFFFFFFFF);
			rd(ADDR_INT_STATUS, 32'h00000000);
		end
		usbTxFrameWaiting <= 1'b1;
		wr(ADDR_INT_STATUS, 32'h00001000);
		rd(ADDR_INT_STATUS, 32'h00001000);
		usbTxFrameWaiting <= 1'b0;
		rd(ADDR_INT_STATUS, 32'h00000000);
		// Data port completion pulse latches.
		@(posedge clk_sys) dataPortDone <= 1'b1;
		@(posedge clk_sys) dataPortDone <= 1'b0;
		rd(ADDR_INT_STATUS, 32'h00000001 << BIT_DP_DONE);
		rd(ADDR_INT_STATUS, 32'h00000001 << BIT_DP_DONE);
		wr(ADDR_INT_STATUS, 32'h00000001 << BIT_DP_DONE);
		rd(ADDR_INT_STATUS, 32'h00000000);
		// A pulse that arrives while the clock enable is low is not seen.
		@(posedge clk_sys) clkEn <= 1'b0;
		@(posedge clk_sys) dataPortDone <= 1'b1;
		@(posedge clk_sys) dataPortDone <= 1'b0;
		@(posedge clk_sys) clkEn <= 1'b1;
		rd(ADDR_INT_STATUS, 32'h00000000);
		// Write into a full FIFO, then data is dropped until the flag is cleared.
		@(posedge clk_sys) {rxFifoFull, rxWriteReq} <= 2'b11;
		@(posedge clk_sys) rxFifoFull <= 1'b0;
		@(negedge clk_sys) chk({31'h0, rxWriteEn}, 32'h00000000);
		@(posedge clk_sys) rxWriteReq <= 1'b0;
		rd(ADDR_INT_STATUS, 32'h00000001 << BIT_RX_OVF);
		wr(ADDR_INT_STATUS, 32'h00000001 << BIT_RX_OVF);
		rxWriteReq <= 1'b1;
		@(negedge clk_sys) chk({31'h0, rxWriteEn}, 32'h00000001);
		@(posedge clk_sys) rxWriteReq <= 1'b0;
		// MAC reset with no PHY clocks runs into the watchdog.
		wr(ADDR_SRC_CTRL, 32'h00000002);
		i = 0;
		while (macResetActive !== 1'b1 && i < 5)
		begin
			@(negedge clk_sys);
			i++;
		end
		chk({31'h0, macResetActive}, 32'h00000001);
		i = 0;
		while (macResetActive === 1'b1 && i < 100)
		begin
			@(negedge clk_sys);
			i++;
		end
		chk(i, WDOG_SIM);
		rd(ADDR_INT_STATUS, 32'h00000001 << BIT_MAC_RTO);
		wr(ADDR_INT_STATUS, 32'h00000001 << BIT_MAC_RTO);
		phyClocksOk <= 1'b1;
		wr(ADDR_SRC_CTRL, 32'h00000002);
		repeat (4) @(negedge clk_sys);
		chk({31'h0, macResetActive}, 32'h00000000);
		rd(ADDR_INT_STATUS, 32'h00000000);
		wr(ADDR_SRC_STATUS, 32'hFFFFFFFF);
		rd(ADDR_SRC_STATUS, 32'h00000002);
		apb(1'b0, 12'h020, 32'h00000000, r, e);
		chk({31'h0, e}, 32'h00000001);
		chk(r, 32'h00000000);
		// Receive idle entry only counts while energy saving is on.
		@(posedge clk_sys) rxIdleEntry <= 1'b1;
		@(posedge clk_sys) rxIdleEntry <= 1'b0;
		rd(ADDR_INT_STATUS, 32'h00000000);
		wr(ADDR_SRC_CTRL, 32'h00000001);
		@(negedge clk_sys);
		chk({31'h0, energySavingEn}, 32'h00000001);
		@(posedge clk_sys) rxIdleEntry <= 1'b1;
		@(posedge clk_sys) rxIdleEntry <= 1'b0;
		rd(ADDR_INT_STATUS, 32'h00000001 << BIT_RX_IDLE);
		wr(ADDR_INT_STATUS, 32'h00000001 << BIT_RX_IDLE);
		rd(ADDR_INT_STATUS, 32'h00000000);
		@(posedge clk_sys) rxIdleEntry <= 1'b1;
		@(posedge clk_sys) rxIdleEntry <= 1'b0;
		wr(ADDR_SRC_CTRL, 32'h00000000);
		rd(ADDR_INT_STATUS, 32'h00000000);
		test_done();
	end
endmodule
`default_nettype wire
